// >>> hdl/i2c_init_pkg.sv
package i2c_init_pkg;
  // =========================================================
  // timing
  localparam int unsigned CLK_NS   = 50;
  localparam int unsigned HALF_NS  = 2500;
  localparam int unsigned HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;

  // =========================================================
  // controller register map (through the cpu interface)
  typedef logic [2:0] addr_t;
  localparam addr_t A_CTRL = 3'h0;
  localparam addr_t A_STAT = 3'h1;
  localparam addr_t A_FLAG = 3'h2;
  localparam addr_t A_CLK  = 3'h3;
  localparam addr_t A_DATA = 3'h4;
  localparam addr_t A_EVT  = 3'h5;
  localparam addr_t A_MASK = 3'h6;
  // control bits
  localparam int C_EN   = 7;
  localparam int C_LREL = 6;
  localparam int C_WREL = 5;
  localparam int C_STT  = 1;
  localparam int C_SPT  = 0;
  // status bits
  localparam int S_MSTR = 7;
  localparam int S_FREE = 5;
  localparam int S_TRC  = 3;
  localparam int S_STD  = 1;
  localparam int S_SPD  = 0;
  // flag bits
  localparam int F_BSY   = 6;
  localparam int F_START_WITHOUT_STOP_ENABLE = 1;
  localparam int F_RSV   = 0;
  // clock select bits
  localparam int K_EXT = 4;
  localparam int K_SMC = 3;
  localparam int K_HI  = 1;
  localparam int K_LO  = 0;
  // event bits
  localparam int E_STD  = 0;
  localparam int E_SPD  = 1;
  localparam int E_WAIT = 2;
  localparam int E_REF  = 3;

  // =========================================================
  // sequencer register map (software port)
  localparam addr_t H_CFG  = 3'h0;
  localparam addr_t H_CMD  = 3'h1;
  localparam addr_t H_DATA = 3'h2;
  localparam addr_t H_STAT = 3'h3;
  localparam addr_t H_EVT  = 3'h4;
  localparam addr_t H_MASK = 3'h5;
  localparam addr_t H_LAST = 3'h6;
  localparam int G_START_WITHOUT_STOP_ENABLE = 5;
  localparam int G_RSV   = 6;
  localparam int M_ON    = 0;
  localparam int M_OFF   = 1;
  localparam int M_STT   = 2;
  localparam int M_SEND  = 3;
  localparam int M_WREL  = 4;
  localparam int M_SPT   = 5;
  localparam int T_BUSY  = 0;
  localparam int T_ON    = 1;
  localparam int V_DONE  = 0;
  localparam int V_ERR   = 1;
  localparam logic [7:0] RST_BYTE = 8'h00;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_START = 3'h1, D_LOW = 3'h2, D_HIGH = 3'h3,
    D_WAIT = 3'h4, D_STOP0 = 3'h5, D_STOP1 = 3'h6, D_STOP2 = 3'h7
  } dev_st_t;

  typedef enum logic [3:0] {
    H_IDLE = 4'h0, H_CLK = 4'h1, H_FLAG = 4'h2, H_EN = 4'h3,
    H_RCTRL = 4'h4, H_LREL = 4'h5, H_RFLAG0 = 4'h6, H_CHK0 = 4'h7,
    H_RSTAT = 4'h8, H_CHK1 = 4'h9, H_RFLAG1 = 4'ha, H_CHK2 = 4'hb,
    H_ONE = 4'hc, H_RWAIT = 4'hd, H_OFF = 4'he
  } host_st_t;
endpackage : i2c_init_pkg

// >>> hdl/i2c_cpu_if.sv
`timescale 1ns/1ps
interface i2c_cpu_if;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rvalid;
  logic       stall;

  modport dev (input addr, wdata, wr, rd, output rdata, rvalid, stall);
  modport sw  (output addr, wdata, wr, rd, input rdata, rvalid, stall);
endinterface : i2c_cpu_if

// >>> hdl/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= {W{1'b1}};
      q_o    <= {W{1'b1}};
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : bit_sync

// >>> hdl/i2c_dev_end.sv
`timescale 1ns/1ps
module i2c_dev_end (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  i2c_cpu_if.dev    bus,
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      scl_oe_o,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_o,
  output logic      irq_o
);
  import i2c_init_pkg::*;

  logic [1:0]  pin_s;
  logic        scl_s, sda_s, scl_p, sda_p;
  logic        en_q, start_without_stop_enable_q, rsv_q, busy_q, std_q, spd_q, trc_q, mstr_q;
  logic        was_wait_q;
  logic [4:0]  clk_q;
  logic [7:0]  data_q, sh_q, rd_mux, stat_val;
  logic [3:0]  evt_q, mask_q, evt_set, bit_q;
  logic [11:0] cnt_q, half;
  dev_st_t     st_q;
  logic        wr_ctrl, en_rise, start_ev, stop_ev, stt_req, refuse;

  // =========================================================
  // pin sampling and bus conditions
  bit_sync #(.W(2)) u_sync (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .d_i      ({scl_i, sda_i}),
    .q_o      (pin_s)
  );
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  assign start_ev = en_q & scl_s & scl_p & sda_p & ~sda_s;
  assign stop_ev  = en_q & scl_s & scl_p & ~sda_p & sda_s;
  assign wr_ctrl  = bus.wr & (bus.addr == A_CTRL);
  assign en_rise  = wr_ctrl & bus.wdata[C_EN] & ~en_q;
  assign stt_req  = wr_ctrl & bus.wdata[C_STT] & en_q;
  assign refuse   = stt_req & (busy_q | (st_q != D_IDLE));

  // =========================================================
  // configuration and bus state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      en_q    <= 1'b0;
      start_without_stop_enable_q <= 1'b0;
      rsv_q   <= 1'b0;
      clk_q   <= '0;
      data_q  <= RST_BYTE;
      mask_q  <= '0;
    end else if (bus.wr) begin
      case (bus.addr)
        A_CTRL:  en_q <= bus.wdata[C_EN];
        A_FLAG:  begin
          start_without_stop_enable_q <= bus.wdata[F_START_WITHOUT_STOP_ENABLE];
          rsv_q   <= bus.wdata[F_RSV];
        end
        A_CLK:   clk_q <= bus.wdata[4:0];
        A_DATA:  data_q <= bus.wdata;
        A_MASK:  mask_q <= bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      busy_q <= 1'b0;
      std_q  <= 1'b0;
      spd_q  <= 1'b0;
    end else if (en_rise) begin
      busy_q <= ~start_without_stop_enable_q;
      std_q  <= scl_s & ~sda_s;
      spd_q  <= 1'b0;
    end else if (!en_q) begin
      busy_q <= 1'b0;
      std_q  <= 1'b0;
      spd_q  <= 1'b0;
    end else begin
      if (start_ev) busy_q <= 1'b1;
      else if (stop_ev) busy_q <= 1'b0;
      if (start_ev) std_q <= 1'b1;
      if (stop_ev) spd_q <= 1'b1;
    end
  end

  // =========================================================
  // transfer engine: start, byte out, ninth-clock wait, stop
  always_comb begin
    half = 12'(HALF_CYC) << {clk_q[K_HI], clk_q[K_LO]};
    if (clk_q[K_SMC]) half = half >> 2;
    if (clk_q[K_EXT]) half = half + 12'(HALF_CYC / 4);
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q     <= D_IDLE;
      cnt_q    <= '0;
      bit_q    <= '0;
      sh_q     <= '0;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      trc_q    <= 1'b0;
      mstr_q   <= 1'b0;
    end else if (wr_ctrl & (~bus.wdata[C_EN] | bus.wdata[C_LREL])) begin
      st_q     <= D_IDLE;
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
      trc_q    <= 1'b0;
      mstr_q   <= 1'b0;
    end else if (wr_ctrl & bus.wdata[C_WREL] & (st_q == D_WAIT)) begin
      st_q     <= D_IDLE;
      scl_oe_o <= 1'b0;
      if (trc_q) begin
        trc_q    <= 1'b0;
        sda_oe_o <= 1'b0;
      end
    end else if (stt_req & ~refuse) begin
      sda_oe_o <= 1'b1;
      cnt_q    <= half;
      mstr_q   <= 1'b1;
      trc_q    <= 1'b1;
      st_q     <= D_START;
    end else if (wr_ctrl & bus.wdata[C_SPT] & en_q & ((st_q == D_IDLE) | (st_q == D_WAIT))) begin
      scl_oe_o <= 1'b1;
      sda_oe_o <= 1'b0;
      cnt_q    <= half;
      st_q     <= D_STOP0;
    end else if (bus.wr & (bus.addr == A_DATA) & (st_q == D_WAIT) & trc_q) begin
      sh_q     <= bus.wdata;
      bit_q    <= '0;
      sda_oe_o <= ~bus.wdata[7];
      cnt_q    <= half;
      st_q     <= D_LOW;
    end else if ((st_q == D_HIGH) & ~scl_s) begin
      // slave stretching the clock
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 12'h001;
    end else begin
      cnt_q <= half;
      case (st_q)
        D_START: begin
          scl_oe_o <= 1'b1;
          st_q     <= D_WAIT;
        end
        D_LOW: begin
          scl_oe_o <= 1'b0;
          st_q     <= D_HIGH;
        end
        D_HIGH: begin
          scl_oe_o <= 1'b1;
          if (bit_q == 4'h8) begin
            sda_oe_o <= 1'b0;
            st_q     <= D_WAIT;
          end else begin
            sda_oe_o <= (bit_q == 4'h7) ? 1'b0 : ~sh_q[6];
            sh_q     <= {sh_q[6:0], 1'b0};
            bit_q    <= bit_q + 4'h1;
            st_q     <= D_LOW;
          end
        end
        D_STOP0: begin
          sda_oe_o <= 1'b1;
          st_q     <= D_STOP1;
        end
        D_STOP1: begin
          scl_oe_o <= 1'b0;
          st_q     <= D_STOP2;
        end
        D_STOP2: begin
          sda_oe_o <= 1'b0;
          mstr_q   <= 1'b0;
          trc_q    <= 1'b0;
          st_q     <= D_IDLE;
        end
        default: ;
      endcase
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // =========================================================
  // events, interrupt
  always_comb begin
    evt_set         = '0;
    evt_set[E_STD]  = start_ev | (en_rise & scl_s & ~sda_s);
    evt_set[E_SPD]  = stop_ev;
    evt_set[E_WAIT] = (st_q == D_WAIT) & ~was_wait_q;
    evt_set[E_REF]  = refuse;
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_q      <= '0;
      was_wait_q <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      was_wait_q <= (st_q == D_WAIT);
      irq_o      <= |(evt_q & mask_q);
      if (bus.wr & (bus.addr == A_EVT)) evt_q <= (evt_q & ~bus.wdata[3:0]) | evt_set;
      else evt_q <= evt_q | evt_set;
    end
  end

  // =========================================================
  // register reads; a status read answers one cycle late
  assign stat_val = {mstr_q, 1'b0, scl_s & sda_s & ~busy_q, 1'b0, trc_q, 1'b0, std_q, spd_q};

  always_comb begin
    case (bus.addr)
      A_CTRL:  rd_mux = {en_q, 7'h00};
      A_FLAG:  rd_mux = {1'b0, busy_q, 4'h0, start_without_stop_enable_q, rsv_q};
      A_CLK:   rd_mux = {3'h0, clk_q};
      A_DATA:  rd_mux = data_q;
      A_EVT:   rd_mux = {4'h0, evt_q};
      A_MASK:  rd_mux = {4'h0, mask_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus.rdata  <= '0;
      bus.rvalid <= 1'b0;
      bus.stall  <= 1'b0;
    end else begin
      bus.rvalid <= 1'b0;
      bus.stall  <= 1'b0;
      if (bus.stall) begin
        bus.rvalid <= 1'b1;
        bus.rdata  <= stat_val;
      end else if (bus.rd & (bus.addr == A_STAT)) begin
        bus.stall <= 1'b1;
      end else if (bus.rd) begin
        bus.rvalid <= 1'b1;
        bus.rdata  <= rd_mux;
      end
    end
  end
endmodule : i2c_dev_end

// >>> hdl/i2c_sw_end.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
// Functional notes
// - enable with clock high, data low: start
// - after enable, set local release by read-modify-write
// - wait release when transmitting: clear role, free data
// - status read inserts one wait cycle
// - start-without-stop written only while disabled
// - reservation disable written only while disabled
// - clock select set before enable, change when disabled
// - no start-without-stop: busy set on enable
// - busy after enable: issue stop before mastering
// - no master start while bus unreleased
// - enable sequence: clock select first, then enable
// - start-without-stop: busy cleared on enable
// - check bus free before first start trigger
module i2c_sw_end (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  i2c_cpu_if.sw                     bus,
  input  wire i2c_init_pkg::addr_t  addr_i,
  input  wire logic [7:0]           wdata_i,
  input  wire logic                 wr_i,
  input  wire logic                 rd_i,
  output logic      [7:0]           rdata_o,
  output logic                      irq_o
);
  import i2c_init_pkg::*;

  logic [6:0] cfg_q;
  logic [7:0] data_q;
  logic [7:0] rd_q;
  logic [7:0] wd_q;
  addr_t      wa_q;
  logic [1:0] evt_q;
  logic [1:0] mask_q;
  logic [1:0] evt_set;
  logic       on_q;
  logic       done_q;
  logic       err_q;
  logic       cfg_ref;
  logic       cmd_wr;
  logic [7:0] rd_mux;
  host_st_t   st_q;
  host_st_t   nx_q;

  // =========================================================
  // software register writes
  assign cmd_wr  = wr_i & (addr_i == H_CMD);
  assign cfg_ref = wr_i & (addr_i == H_CFG) & on_q;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cfg_q  <= '0;
      data_q <= RST_BYTE;
      mask_q <= '0;
    end else if (wr_i) begin
      case (addr_i)
        H_CFG:   if (!on_q) cfg_q <= wdata_i[6:0];
        H_DATA:  data_q <= wdata_i;
        H_MASK:  mask_q <= wdata_i[1:0];
        default: ;
      endcase
    end
  end

  // =========================================================
  // command sequencer driving the controller
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_q      <= H_IDLE;
      nx_q      <= H_IDLE;
      wa_q      <= A_CTRL;
      wd_q      <= '0;
      rd_q      <= '0;
      on_q      <= 1'b0;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      bus.wr    <= 1'b0;
      bus.rd    <= 1'b0;
      bus.addr  <= A_CTRL;
      bus.wdata <= '0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (cmd_wr) begin
            if (wdata_i[M_ON]) begin
              if (on_q) err_q <= 1'b1;
              else begin
                on_q <= 1'b1;
                st_q <= H_CLK;
              end
            end else if (wdata_i[M_OFF]) begin
              st_q <= H_OFF;
            end else if (!on_q) begin
              err_q <= 1'b1;
            end else if (wdata_i[M_STT]) begin
              st_q <= H_RSTAT;
            end else if (wdata_i[M_SEND]) begin
              wa_q <= A_DATA;
              wd_q <= data_q;
              st_q <= H_ONE;
            end else if (wdata_i[M_WREL]) begin
              wa_q <= A_CTRL;
              wd_q <= 8'h80 | 8'h20;
              st_q <= H_ONE;
            end else if (wdata_i[M_SPT]) begin
              wa_q <= A_CTRL;
              wd_q <= 8'h80 | 8'h01;
              st_q <= H_ONE;
            end
          end
        end
        H_CLK: begin
          bus.wr    <= 1'b1;
          bus.addr  <= A_CLK;
          bus.wdata <= {3'h0, cfg_q[4:0]};
          st_q      <= H_FLAG;
        end
        H_FLAG: begin
          bus.wr    <= 1'b1;
          bus.addr  <= A_FLAG;
          bus.wdata <= '0;
          bus.wdata[F_START_WITHOUT_STOP_ENABLE] <= cfg_q[G_START_WITHOUT_STOP_ENABLE];
          bus.wdata[F_RSV]   <= cfg_q[G_RSV];
          st_q      <= H_EN;
        end
        H_EN: begin
          bus.wr    <= 1'b1;
          bus.addr  <= A_CTRL;
          bus.wdata <= '0;
          bus.wdata[C_EN] <= 1'b1;
          st_q      <= H_RCTRL;
        end
        H_RCTRL: begin
          bus.rd   <= 1'b1;
          bus.addr <= A_CTRL;
          nx_q     <= H_LREL;
          st_q     <= H_RWAIT;
        end
        H_LREL: begin
          bus.wr    <= 1'b1;
          bus.addr  <= A_CTRL;
          bus.wdata <= rd_q;
          bus.wdata[C_LREL] <= 1'b1;
          st_q      <= cfg_q[G_START_WITHOUT_STOP_ENABLE] ? H_IDLE : H_RFLAG0;
          done_q    <= cfg_q[G_START_WITHOUT_STOP_ENABLE];
        end
        H_RFLAG0: begin
          bus.rd   <= 1'b1;
          bus.addr <= A_FLAG;
          nx_q     <= H_CHK0;
          st_q     <= H_RWAIT;
        end
        H_CHK0: begin
          if (rd_q[F_BSY]) begin
            bus.wr    <= 1'b1;
            bus.addr  <= A_CTRL;
            bus.wdata <= '0;
            bus.wdata[C_EN]  <= 1'b1;
            bus.wdata[C_SPT] <= 1'b1;
          end
          done_q <= 1'b1;
          st_q   <= H_IDLE;
        end
        H_RSTAT: begin
          bus.rd   <= 1'b1;
          bus.addr <= A_STAT;
          nx_q     <= H_CHK1;
          st_q     <= H_RWAIT;
        end
        H_CHK1: begin
          if (!rd_q[S_FREE]) begin
            err_q <= 1'b1;
            st_q  <= H_IDLE;
          end else begin
            st_q  <= H_RFLAG1;
          end
        end
        H_RFLAG1: begin
          bus.rd   <= 1'b1;
          bus.addr <= A_FLAG;
          nx_q     <= H_CHK2;
          st_q     <= H_RWAIT;
        end
        H_CHK2: begin
          if (rd_q[F_BSY]) begin
            err_q <= 1'b1;
          end else begin
            bus.wr    <= 1'b1;
            bus.addr  <= A_CTRL;
            bus.wdata <= '0;
            bus.wdata[C_EN]  <= 1'b1;
            bus.wdata[C_STT] <= 1'b1;
            done_q    <= 1'b1;
          end
          st_q <= H_IDLE;
        end
        H_ONE: begin
          bus.wr    <= 1'b1;
          bus.addr  <= wa_q;
          bus.wdata <= wd_q;
          done_q    <= 1'b1;
          st_q      <= H_IDLE;
        end
        H_RWAIT: begin
          if (bus.rvalid) begin
            rd_q <= bus.rdata;
            st_q <= nx_q;
          end
        end
        H_OFF: begin
          bus.wr    <= 1'b1;
          bus.addr  <= A_CTRL;
          bus.wdata <= '0;
          on_q      <= 1'b0;
          done_q    <= 1'b1;
          st_q      <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
      if (cmd_wr & (st_q != H_IDLE)) err_q <= 1'b1;
    end
  end

  // =========================================================
  // events, interrupt, read port
  assign evt_set = {err_q | cfg_ref, done_q};

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      evt_q <= '0;
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(evt_q & mask_q);
      if (wr_i & (addr_i == H_EVT)) evt_q <= (evt_q & ~wdata_i[1:0]) | evt_set;
      else evt_q <= evt_q | evt_set;
    end
  end

  always_comb begin
    case (addr_i)
      H_CFG:   rd_mux = {1'b0, cfg_q};
      H_DATA:  rd_mux = data_q;
      H_STAT:  rd_mux = {6'h00, on_q, st_q != H_IDLE};
      H_EVT:   rd_mux = {6'h00, evt_q};
      H_MASK:  rd_mux = {6'h00, mask_q};
      H_LAST:  rd_mux = rd_q;
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) rdata_o <= '0;
    else if (rd_i) rdata_o <= rd_mux;
  end
endmodule : i2c_sw_end

// >>> tb/i2c_init_checker.sv
`timescale 1ns/1ps
module i2c_init_checker (
  input  wire logic                clk_i,
  input  wire logic                arst_n_i,
  input  wire i2c_init_pkg::addr_t addr,
  input  wire logic [7:0]          wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  input  wire logic [7:0]          rdata,
  input  wire logic                rvalid,
  input  wire logic                stall,
  input  wire logic                scl_oe_o,
  input  wire logic                sda_oe_o,
  input  wire logic                scl,
  input  wire logic                sda
);
  import i2c_init_pkg::*;
  // =========================================================
  // helper state
  logic  en_q, clk_q, start_without_stop_enable_q, unrel_q, fresh_q, bsy_q, sd_q, free_q, scl_q, sda_q;
  addr_t ra_q;
  wire   ctl_w  = wr && addr == A_CTRL;
  wire   en_w   = ctl_w && wdata[C_EN] && !en_q;
  wire   trg_w  = ctl_w && (wdata[C_STT] || wdata[C_SPT]);
  wire   edge_w = (scl != scl_q) || (sda != sda_q);
  wire   stop_w = scl && scl_q && sda && !sda_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {en_q, clk_q, start_without_stop_enable_q, unrel_q, fresh_q, bsy_q, sd_q, free_q} <= '0;
      {scl_q, sda_q} <= 2'b11;
      ra_q <= A_CTRL;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      if (ctl_w) en_q <= wdata[C_EN];
      if (wr && addr == A_CLK) clk_q <= 1'b1;
      else if (ctl_w && !wdata[C_EN]) clk_q <= 1'b0;
      if (wr && addr == A_FLAG) start_without_stop_enable_q <= wdata[F_START_WITHOUT_STOP_ENABLE];
      if (en_w) unrel_q <= !start_without_stop_enable_q;
      else if (stop_w) unrel_q <= 1'b0;
      if (en_w) fresh_q <= scl && sda;
      else if (edge_w || trg_w) fresh_q <= 1'b0;
      if (en_w) bsy_q <= !start_without_stop_enable_q;
      if (en_w) sd_q <= scl && !sda;
      else if (edge_w || trg_w) sd_q <= 1'b0;
      if (rd) ra_q <= addr;
      if (rvalid && ra_q == A_STAT) free_q <= rdata[S_FREE];
      else if (ctl_w && wdata[C_STT]) free_q <= 1'b0;
    end
  end
  // =========================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  stat_wait_a: assert property (rd && addr == A_STAT |=> stall ##1 (rvalid && !stall))
    else $error("status read without a wait cycle");
  stall_src_a: assert property (stall |-> $past(rd) && $past(addr) == A_STAT)
    else $error("wait cycle without a status read");
  busy_init_a: assert property (rvalid && ra_q == A_FLAG && fresh_q |-> rdata[F_BSY] == bsy_q)
    else $error("busy flag wrong after enable");
  start_seen_a: assert property (rvalid && ra_q == A_STAT && sd_q |-> rdata[S_STD])
    else $error("start not seen at enable");
  wait_rel_a: assert property (ctl_w && wdata[C_WREL] && scl_oe_o && !sda_oe_o
    |-> ##[1:4] !scl_oe_o ##1 !sda_oe_o[*3]) else $error("wait release failed");
  clk_first_a: assert property (en_w |-> clk_q)
    else $error("enable before clock select");
  clk_wr_a: assert property (wr && addr == A_CLK |-> !en_q)
    else $error("clock select written while enabled");
  flag_wr_a: assert property (wr && addr == A_FLAG |-> !en_q)
    else $error("flag register written while enabled");
  lrel_rmw_a: assert property (en_w |-> ##[1:8] (ctl_w && wdata[C_LREL] && wdata[C_EN]))
    else $error("local release not set after enable");
  stop_first_a: assert property (ctl_w && wdata[C_STT] |-> !unrel_q)
    else $error("start while bus unreleased");
  free_chk_a: assert property (ctl_w && wdata[C_STT] |-> free_q)
    else $error("start without bus free check");
endmodule : i2c_init_checker

// >>> tb/i2c_enable_bus_status_init_tb.sv
`timescale 1ns/1ps
module i2c_enable_bus_status_init_tb;
  import i2c_init_pkg::*;
  logic       clk_i, arst_n_i, wr_i, rd_i, scl_low, sda_low, cap;
  addr_t      addr_i;
  logic [7:0] wdata_i, rdata_o, cfg_m, byte_m;
  logic       irq_sw, irq_dev, scl_oe, sda_oe, scl_o, sda_o;
  int         n_errors, tests_run, seed, on_m;
  logic       bits[$];
  wire        scl = ~(scl_oe | scl_low);
  wire        sda = ~(sda_oe | sda_low);
  i2c_cpu_if cif ();
  i2c_dev_end i_i2c_dev_end (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(cif.dev), .scl_i(scl),
    .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .irq_o(irq_dev));
  i2c_sw_end i_i2c_sw_end (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus(cif.sw), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_sw));
  i2c_init_checker i_i2c_init_checker (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr(cif.addr),
    .wdata(cif.wdata), .wr(cif.wr), .rd(cif.rd), .rdata(cif.rdata), .rvalid(cif.rvalid),
    .stall(cif.stall), .scl_oe_o(scl_oe), .sda_oe_o(sda_oe), .scl(scl), .sda(sda));
  // =========================================================
  // wire monitor
  always @(posedge scl) begin
    if (cap) bits.push_back(sda);
  end
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // =========================================================
  // tasks
  task automatic test_done();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic chk_bit(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_bit
  task automatic wr_t(input addr_t a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr_t
  task automatic rd_t(input addr_t a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd_t
  // bounded wait on the lines: 0 both high, 1 clock held low, 2 nine bits then clock low
  task automatic wait_bus(input int m);
    int k;
    for (k = 0; k < 20000; k++) begin
      if (m == 0 ? (scl === 1'b1 && sda === 1'b1)
                 : (scl === 1'b0 && (m == 1 || bits.size() == 9))) break;
      @(posedge clk_i);
    end
    if (k == 20000) begin
      n_errors++;
      test_done();
    end
    repeat (4) @(posedge clk_i);
  endtask : wait_bus
  // model of the command outcome: done or error event
  function automatic logic [7:0] model(input int c, input bit bad);
    if ((on_m == 0 && c != M_ON) || bad) return 8'h02;
    if (c == M_ON) on_m = 1;
    if (c == M_OFF) on_m = 0;
    return 8'h01;
  endfunction : model
  task automatic cmd(input int c, input logic [7:0] exp);
    logic [7:0] d;
    int         k;
    wr_t(H_CMD, 8'h01 << c);
    d = 8'h01;
    for (k = 0; k < 10000 && d[T_BUSY] !== 1'b0; k++) rd_t(H_STAT, d);
    if (k == 10000) begin
      n_errors++;
      test_done();
    end
    rd_t(H_EVT, d);
    check("event", exp, d);
    chk_bit("irq", exp[V_ERR], irq_sw);
    wr_t(H_EVT, 8'h03);
    rd_t(H_EVT, d);
    check("event cleared", 8'h00, d);
    chk_bit("irq cleared", 1'b0, irq_sw);
  endtask : cmd
  // =========================================================
  // main sequence
  initial begin
    logic [7:0] d;
    {arst_n_i, wr_i, rd_i, scl_low, sda_low, cap} = '0;
    addr_i    = H_CFG;
    wdata_i   = 8'h00;
    n_errors  = 0;
    tests_run = 0;
    on_m      = 0;
    seed      = 19609;
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      rd_t(addr_t'(k), d);
      check("reset value", (k == H_LAST) ? RST_BYTE : 8'h00, d);
    end
    wr_t(H_MASK, 8'h02);
    cmd(M_STT, model(M_STT, 0));
    for (int s = 0; s < 2; s++) begin
      cfg_m = 8'($random(seed)) & 8'h5f;
      cfg_m[G_START_WITHOUT_STOP_ENABLE] = s[0];
      wr_t(H_CFG, cfg_m);
      cmd(M_ON, model(M_ON, 0));
      wait_bus(0);
      wr_t(H_CFG, ~cfg_m);
      rd_t(H_CFG, d);
      check("config locked", cfg_m, d);
      rd_t(H_EVT, d);
      check("config refused", 8'h02, d);
      wr_t(H_EVT, 8'h03);
      rd_t(H_STAT, d);
      check("on state", 8'h02, d);
      wr_t(H_CMD, 8'h01 << M_STT);
      cmd(M_SEND, model(M_STT, 0) | model(M_SEND, 1));
      wait_bus(1);
      byte_m = 8'($random(seed));
      wr_t(H_DATA, byte_m);
      bits.delete();
      cap = 1'b1;
      cmd(M_SEND, model(M_SEND, 0));
      wait_bus(2);
      cap = 1'b0;
      check("bit count", 8'd9, 8'(bits.size()));
      for (int k = 0; k < 8; k++) chk_bit("data bit", byte_m[7-k], bits[k]);
      chk_bit("ack slot", 1'b1, bits[8]);
      cmd(M_WREL, model(M_WREL, 0));
      chk_bit("sda freed", 1'b1, sda);
      chk_bit("scl freed", 1'b1, scl);
      cmd(M_SPT, model(M_SPT, 0));
      wait_bus(0);
      chk_bit("scl idle", 1'b1, scl);
      chk_bit("sda idle", 1'b1, sda);
      cmd(M_OFF, model(M_OFF, 0));
    end
    cfg_m = 8'h20;
    wr_t(H_CFG, cfg_m);
    sda_low <= 1'b1;
    cmd(M_ON, model(M_ON, 0));
    cmd(M_STT, model(M_STT, 1));
    rd_t(H_LAST, d);
    chk_bit("start seen", 1'b1, d[S_STD]);
    sda_low <= 1'b0;
    cmd(M_OFF, model(M_OFF, 0));
    test_done();
  end
endmodule : i2c_enable_bus_status_init_tb
